// ---- verilog/oag_core.sv ----
// operand address generation: working registers, mode checks, routing
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - file direct: explicit instruction address used
// R2 - register direct: register contents are operand
// R3 - indirect: base pointer value is address
// R4 - post-modify: use base, then step it
// R5 - pre-modify: step base, then use it
// R6 - register offset: base plus offset register
// R7 - literal offset: base plus instruction literal
// R8 - register offset only for move/accumulator class
// R9 - one offset selector serves source and destination
// R10 - decoder names prefetch pointers only 8..11
// R11 - pointers 8,9 to X; 10,11 to Y
// R12 - issuer keeps prefetch addresses in own space
// R13 - dual-source indexed only via 9 and 11
// R14 - dual-source: indirect, indexed, post-step 2/4/6
// R15 - branch literal is 16-bit signed target
// R16 - interrupt disable literal is 14-bit unsigned
// R17 - implied operands need no addressing field
// R18 - offset modes leave base pointer unchanged
module oag_core
  import oag_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // decoded instruction
  input wire oag_instr_s instr_i,
  // working register write from the datapath
  input wire logic wr_en_i,
  input wire logic [SEL_W-1:0] wr_sel_i,
  input wire logic [W_WIDTH-1:0] wr_data_i,
  // result toward execute and the data spaces
  output oag_res_s res_o
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // working register read, used by every slot
  function automatic logic [W_WIDTH-1:0] rd_w(
    input logic [NUM_WREG-1:0][W_WIDTH-1:0] regs,
    input logic [SEL_W-1:0] sel
  );
    rd_w = regs[sel];
  endfunction : rd_w

  // step magnitude must be one of the three allowed sizes
  function automatic logic step_ok(input logic [W_WIDTH-1:0] lit);
    logic [W_WIDTH-1:0] mag;
    mag = lit[W_WIDTH-1] ? W_WIDTH'(-lit) : lit;
    step_ok = (mag == DUAL_STEP_2) || (mag == DUAL_STEP_4) || (mag == DUAL_STEP_6);
  endfunction : step_ok

  // legality of one prefetch request
  function automatic logic dual_ok(input oag_ea_req_s req, input logic is_x);
    logic in_set;
    logic idx_reg;
    in_set = is_x ? (req.base_sel == X_PREFETCH_POINTER_A || req.base_sel == X_PREFETCH_POINTER_B)
                  : (req.base_sel == Y_PREFETCH_POINTER_A || req.base_sel == Y_PREFETCH_POINTER_B);
    idx_reg = is_x ? (req.base_sel == X_PREFETCH_POINTER_B)
                   : (req.base_sel == Y_PREFETCH_POINTER_B);
    dual_ok = 1'b0;
    if (in_set) begin
      unique case (req.mode)
        OAG_M_IND: dual_ok = 1'b1;
        OAG_M_POST: dual_ok = step_ok(req.lit); // [R14]
        OAG_M_REGOFS: dual_ok = idx_reg; // [R13]
        default: dual_ok = 1'b0; // any other mode refused [R14]
      endcase
    end
  endfunction : dual_ok

  // legality of the whole instruction
  function automatic logic instr_ok(input oag_instr_s ins);
    instr_ok = 1'b1;
    unique case (ins.iclass)
      OAG_C_ORD: instr_ok = (ins.src.mode != OAG_M_REGOFS)
                         && (ins.dst.mode != OAG_M_REGOFS); // [R8]
      OAG_C_DUAL: instr_ok = dual_ok(ins.xreq, 1'b1) && dual_ok(ins.yreq, 1'b0); // [R10]
      default: instr_ok = 1'b1;
    endcase
  endfunction : instr_ok

  // ----------------------------------------------------------------
  // state and slot wiring
  // ----------------------------------------------------------------
  oag_state_s st_r; // everything the core remembers
  oag_state_s st_nxt; // next value of it
  oag_ea_req_s req_a [NUM_CALC]; // one request per calculator
  logic [W_WIDTH-1:0] base_val [NUM_CALC]; // base pointer contents per slot
  logic [W_WIDTH-1:0] ofs_val; // shared offset register contents
  logic [W_WIDTH-1:0] ea_c [NUM_CALC]; // computed addresses
  logic [W_WIDTH-1:0] ptr_c [NUM_CALC]; // updated pointers
  logic wb_c [NUM_CALC]; // pointer write-back wanted
  logic mem_c [NUM_CALC]; // slot addresses memory
  logic legal_c; // instruction passes mode checks

  assign req_a[SLOT_SRC] = instr_i.src;
  assign req_a[SLOT_DST] = instr_i.dst;
  assign req_a[SLOT_X] = instr_i.xreq;
  assign req_a[SLOT_Y] = instr_i.yreq;
  // a single offset selector for every slot keeps the register file to one extra port
  assign ofs_val = rd_w(st_r.wreg, instr_i.ofs_sel); // [R9]
  assign legal_c = instr_ok(instr_i);

  // one calculator per slot
  for (genvar i = 0; i < NUM_CALC; i++) begin : g_calc
    assign base_val[i] = rd_w(st_r.wreg, req_a[i].base_sel);
    oag_ea_calc u_calc (
      .mode_i(req_a[i].mode),
      .base_i(base_val[i]),
      .ofs_i(ofs_val),
      .lit_i(req_a[i].lit),
      .file_addr_i(req_a[i].file_addr),
      .ea_o(ea_c[i]),
      .ptr_o(ptr_c[i]),
      .wb_o(wb_c[i]),
      .mem_o(mem_c[i])
    );
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // pointer write-backs are applied after the datapath write, so an
  // addressing update wins a clash; destination beats source, Y beats X
  always_comb begin
    st_nxt = st_r;
    st_nxt.res = '0;
    if (wr_en_i) begin
      st_nxt.wreg[wr_sel_i] = wr_data_i;
    end
    if (instr_i.valid) begin
      st_nxt.res.valid = 1'b1;
      st_nxt.res.illegal = !legal_c;
      if (legal_c) begin
        unique case (instr_i.iclass)
          OAG_C_ORD, OAG_C_MOVE: begin // source and destination slots
            st_nxt.res.src_ea = ea_c[SLOT_SRC]; // [R1] [R3] [R6] [R7]
            st_nxt.res.dst_ea = ea_c[SLOT_DST];
            st_nxt.res.src_is_mem = mem_c[SLOT_SRC];
            st_nxt.res.dst_is_mem = mem_c[SLOT_DST];
            st_nxt.res.src_opnd = base_val[SLOT_SRC]; // [R2]
            if (wb_c[SLOT_SRC]) begin
              st_nxt.wreg[instr_i.src.base_sel] = ptr_c[SLOT_SRC]; // [R4] [R5] [R18]
            end
            if (wb_c[SLOT_DST]) begin
              st_nxt.wreg[instr_i.dst.base_sel] = ptr_c[SLOT_DST]; // [R4] [R5] [R18]
            end
          end
          OAG_C_DUAL: begin // prefetch pointers routed by register number
            st_nxt.res.x_en = 1'b1; // [R11]
            st_nxt.res.x_addr = ea_c[SLOT_X];
            st_nxt.res.y_en = 1'b1;
            st_nxt.res.y_addr = ea_c[SLOT_Y];
            if (wb_c[SLOT_X]) begin
              st_nxt.wreg[instr_i.xreq.base_sel] = ptr_c[SLOT_X];
            end
            if (wb_c[SLOT_Y]) begin
              st_nxt.wreg[instr_i.yreq.base_sel] = ptr_c[SLOT_Y];
            end
          end
          OAG_C_BRANCH: st_nxt.res.target = instr_i.branch_lit; // [R15]
          OAG_C_INTDIS: st_nxt.res.intdis_cnt = instr_i.intdis_lit; // [R16]
          OAG_C_IMPL: st_nxt.res.implied = 1'b1; // [R17]
          default: st_nxt.res.illegal = 1'b1; // corrupt class code
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // working registers clear at reset so pointers start at a known address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_o = st_r.res;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic go_ls; // legal load/store style instruction this cycle
  logic quiet_dst; // destination cannot disturb the source pointer
  assign go_ls = instr_i.valid && legal_c
              && (instr_i.iclass == OAG_C_ORD || instr_i.iclass == OAG_C_MOVE);
  assign quiet_dst = !wr_en_i && !wb_c[SLOT_DST];

  file_direct_a: assert property ( // [R1]
    go_ls && instr_i.src.mode == OAG_M_FILE
    |=> res_o.src_is_mem && res_o.src_ea == $past(instr_i.src.file_addr))
    else $error("file direct address not taken from instruction");

  reg_direct_a: assert property ( // [R2]
    go_ls && instr_i.src.mode == OAG_M_REG
    |=> !res_o.src_is_mem && res_o.src_opnd == $past(base_val[SLOT_SRC]))
    else $error("register direct operand wrong");

  ind_plain_a: assert property ( // [R3]
    go_ls && instr_i.src.mode == OAG_M_IND && quiet_dst
    |=> res_o.src_ea == $past(base_val[SLOT_SRC])
        && st_r.wreg[$past(instr_i.src.base_sel)] == $past(base_val[SLOT_SRC]))
    else $error("plain indirect address or pointer wrong");

  post_mod_a: assert property ( // [R4]
    go_ls && instr_i.src.mode == OAG_M_POST && quiet_dst
    |=> res_o.src_ea == $past(base_val[SLOT_SRC])
        && st_r.wreg[$past(instr_i.src.base_sel)]
           == W_WIDTH'($past(base_val[SLOT_SRC]) + $past(instr_i.src.lit)))
    else $error("post-modify used wrong address or step");

  pre_mod_a: assert property ( // [R5]
    go_ls && instr_i.src.mode == OAG_M_PRE && quiet_dst
    |=> res_o.src_ea == st_r.wreg[$past(instr_i.src.base_sel)]
        && res_o.src_ea == W_WIDTH'($past(base_val[SLOT_SRC]) + $past(instr_i.src.lit)))
    else $error("pre-modify address differs from updated pointer");

  reg_ofs_a: assert property ( // [R6] [R9]
    go_ls && instr_i.dst.mode == OAG_M_REGOFS
    |=> res_o.dst_ea == W_WIDTH'($past(base_val[SLOT_DST]) + $past(ofs_val)))
    else $error("indexed address not base plus offset register");

  lit_ofs_a: assert property ( // [R7] [R18]
    go_ls && instr_i.src.mode == OAG_M_LITOFS && quiet_dst
    |=> res_o.src_ea == W_WIDTH'($past(base_val[SLOT_SRC]) + $past(instr_i.src.lit))
        && st_r.wreg[$past(instr_i.src.base_sel)] == $past(base_val[SLOT_SRC]))
    else $error("literal offset address wrong or pointer changed");

  ord_index_a: assert property ( // [R8]
    instr_i.valid && instr_i.iclass == OAG_C_ORD && instr_i.src.mode == OAG_M_REGOFS
    |=> res_o.valid && res_o.illegal && !res_o.src_is_mem)
    else $error("ordinary instruction accepted indexed mode");

  dual_route_a: assert property ( // [R11]
    instr_i.valid && legal_c && instr_i.iclass == OAG_C_DUAL
    |=> res_o.x_en && res_o.y_en && res_o.x_addr == $past(ea_c[SLOT_X])
        && res_o.y_addr == $past(ea_c[SLOT_Y]) ##1 !res_o.x_en || $past(instr_i.valid))
    else $error("prefetch pointers not routed to X and Y");

  dual_index_a: assert property ( // [R13]
    instr_i.valid && instr_i.iclass == OAG_C_DUAL && instr_i.xreq.mode == OAG_M_REGOFS
    && instr_i.xreq.base_sel == X_PREFETCH_POINTER_A
    |=> res_o.illegal && !res_o.x_en && !res_o.y_en)
    else $error("indexed prefetch allowed through wrong pointer");

  dual_step_a: assert property ( // [R14]
    instr_i.valid && instr_i.iclass == OAG_C_DUAL && instr_i.yreq.mode == OAG_M_POST
    && !step_ok(instr_i.yreq.lit)
    |=> res_o.illegal && !res_o.y_en)
    else $error("prefetch step outside allowed sizes accepted");

  branch_lit_a: assert property ( // [R15]
    instr_i.valid && instr_i.iclass == OAG_C_BRANCH
    |=> res_o.target == $past(instr_i.branch_lit) && !res_o.src_is_mem)
    else $error("branch target not the literal");

  intdis_lit_a: assert property ( // [R16]
    instr_i.valid && instr_i.iclass == OAG_C_INTDIS
    |=> res_o.intdis_cnt == $past(instr_i.intdis_lit) && !res_o.illegal)
    else $error("interrupt disable count not the literal");

  implied_a: assert property ( // [R17]
    instr_i.valid && instr_i.iclass == OAG_C_IMPL
    |=> res_o.implied && !res_o.src_is_mem && !res_o.dst_is_mem)
    else $error("implied operand produced an address");

  post_mod_c: cover property (go_ls && instr_i.src.mode == OAG_M_POST);
  move_index_c: cover property (go_ls && instr_i.iclass == OAG_C_MOVE
                                && instr_i.src.mode == OAG_M_REGOFS);
  dual_c: cover property (instr_i.valid && legal_c && instr_i.iclass == OAG_C_DUAL
                          ##1 instr_i.valid && instr_i.iclass == OAG_C_DUAL);
  illegal_c: cover property (instr_i.valid && !legal_c);

endmodule : oag_core

`default_nettype wire

// ---- verilog/oag_pkg.sv ----
// operand address generation: shared types and constants
package oag_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int W_WIDTH = 16; // data word and address width
  localparam int NUM_WREG = 16; // working registers
  localparam int SEL_W = 4; // register selector width, offset selector too
  localparam int BRANCH_LIT_W = 16; // branch literal, signed
  localparam int INTDIS_LIT_W = 14; // interrupt disable literal, unsigned
  localparam int NUM_CALC = 4; // src, dst, x prefetch, y prefetch

  // ----------------------------------------------------------------
  // fixed register numbers for dual-source prefetch
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] X_PREFETCH_POINTER_A = 4'h8;
  localparam logic [SEL_W-1:0] X_PREFETCH_POINTER_B = 4'h9;
  localparam logic [SEL_W-1:0] Y_PREFETCH_POINTER_A = 4'hA;
  localparam logic [SEL_W-1:0] Y_PREFETCH_POINTER_B = 4'hB;

  // ----------------------------------------------------------------
  // allowed prefetch post-modify step magnitudes
  // ----------------------------------------------------------------
  localparam logic [W_WIDTH-1:0] DUAL_STEP_2 = 16'h0002;
  localparam logic [W_WIDTH-1:0] DUAL_STEP_4 = 16'h0004;
  localparam logic [W_WIDTH-1:0] DUAL_STEP_6 = 16'h0006;

  // calculator slot indices
  localparam int SLOT_SRC = 0;
  localparam int SLOT_DST = 1;
  localparam int SLOT_X = 2;
  localparam int SLOT_Y = 3;

  // addressing modes, one-hot
  typedef enum logic [6:0] {
    OAG_M_FILE = 7'h01, // explicit file address
    OAG_M_REG = 7'h02, // register contents are the operand
    OAG_M_IND = 7'h04, // base pointer is the address
    OAG_M_POST = 7'h08, // use base, then modify it
    OAG_M_PRE = 7'h10, // modify base, then use it
    OAG_M_REGOFS = 7'h20, // base plus offset register
    OAG_M_LITOFS = 7'h40 // base plus instruction literal
  } oag_mode_e;

  // instruction classes, one-hot
  typedef enum logic [5:0] {
    OAG_C_ORD = 6'h01, // ordinary instruction
    OAG_C_MOVE = 6'h02, // move and accumulator class
    OAG_C_DUAL = 6'h04, // dual-source operand class
    OAG_C_BRANCH = 6'h08, // branch instruction
    OAG_C_INTDIS = 6'h10, // interrupt disable instruction
    OAG_C_IMPL = 6'h20 // operand implied by opcode
  } oag_class_e;

  // one effective-address request
  typedef struct packed {
    oag_mode_e mode;
    logic [SEL_W-1:0] base_sel; // base pointer register number
    logic [W_WIDTH-1:0] lit; // signed modifier or literal offset
    logic [W_WIDTH-1:0] file_addr; // explicit address
  } oag_ea_req_s;

  // decoded instruction from the decoder
  typedef struct packed {
    logic valid;
    oag_class_e iclass;
    oag_ea_req_s src;
    oag_ea_req_s dst;
    oag_ea_req_s xreq;
    oag_ea_req_s yreq;
    logic [SEL_W-1:0] ofs_sel; // one offset register for all slots
    logic [BRANCH_LIT_W-1:0] branch_lit;
    logic [INTDIS_LIT_W-1:0] intdis_lit;
  } oag_instr_s;

  // result toward the data spaces and execute stage
  typedef struct packed {
    logic valid;
    logic illegal;
    logic implied;
    logic src_is_mem;
    logic dst_is_mem;
    logic [W_WIDTH-1:0] src_ea;
    logic [W_WIDTH-1:0] dst_ea;
    logic [W_WIDTH-1:0] src_opnd;
    logic x_en;
    logic [W_WIDTH-1:0] x_addr;
    logic y_en;
    logic [W_WIDTH-1:0] y_addr;
    logic [BRANCH_LIT_W-1:0] target;
    logic [INTDIS_LIT_W-1:0] intdis_cnt;
  } oag_res_s;

  // whole state of the core
  typedef struct packed {
    logic [NUM_WREG-1:0][W_WIDTH-1:0] wreg;
    oag_res_s res;
  } oag_state_s;

endpackage : oag_pkg

// ---- verilog/oag_ea_calc.sv ----
// operand address generation: single effective-address calculator
`timescale 1ns/1ps
`default_nettype none

module oag_ea_calc
  import oag_pkg::*;
(
  // request
  input wire oag_mode_e mode_i,
  input wire logic [W_WIDTH-1:0] base_i,
  input wire logic [W_WIDTH-1:0] ofs_i,
  input wire logic [W_WIDTH-1:0] lit_i,
  input wire logic [W_WIDTH-1:0] file_addr_i,
  // answer
  output logic [W_WIDTH-1:0] ea_o,
  output logic [W_WIDTH-1:0] ptr_o,
  output logic wb_o,
  output logic mem_o
);

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  logic [W_WIDTH-1:0] mod_sum; // base plus signed constant
  logic [W_WIDTH-1:0] ofs_sum; // base plus offset register

  // wraps at the word width, like the pointer itself
  assign mod_sum = W_WIDTH'(base_i + lit_i);
  assign ofs_sum = W_WIDTH'(base_i + ofs_i);

  // mode select; pure logic, the caller registers everything
  always_comb begin
    ea_o = base_i;
    ptr_o = base_i;
    wb_o = 1'b0;
    mem_o = 1'b1;
    unique case (mode_i)
      OAG_M_FILE: ea_o = file_addr_i; // [R1]
      OAG_M_REG: mem_o = 1'b0; // [R2]
      OAG_M_IND: ea_o = base_i; // [R3]
      OAG_M_POST: begin // [R4]
        ea_o = base_i;
        ptr_o = mod_sum;
        wb_o = 1'b1;
      end
      OAG_M_PRE: begin // [R5]
        ea_o = mod_sum;
        ptr_o = mod_sum;
        wb_o = 1'b1;
      end
      OAG_M_REGOFS: ea_o = ofs_sum; // [R6] [R18]
      OAG_M_LITOFS: ea_o = mod_sum; // [R7] [R18]
      default: mem_o = 1'b0; // illegal code: no access, no write
    endcase
  end

endmodule : oag_ea_calc

`default_nettype wire

// ---- sim/oag_dspace_model.sv ----
// X and Y data space model at the far side of the address generator
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// data space model
// ----------------------------------------------------------------
module oag_dspace_model
  import oag_pkg::*;
#(
  parameter logic [W_WIDTH-1:0] X_LAST = 16'h17FF, // top of X space, plain default
  parameter logic [W_WIDTH-1:0] Y_LAST = 16'h27FF // top of Y space, plain default
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // addresses from the generator
  input wire oag_res_s res,
  // access counts for the bench
  output var int x_rd_cnt,
  output var int y_rd_cnt,
  output var int bad_cnt
);
  // count prefetch reads; a read outside its serving space is counted as bad
  // one adder for both spaces, so two bad reads in one cycle are not lost
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      x_rd_cnt <= 0;
      y_rd_cnt <= 0;
      bad_cnt <= 0;
    end else begin
      x_rd_cnt <= x_rd_cnt + int'(res.x_en === 1'b1);
      y_rd_cnt <= y_rd_cnt + int'(res.y_en === 1'b1);
      bad_cnt <= bad_cnt + int'(res.x_en === 1'b1 && res.x_addr > X_LAST)
        + int'(res.y_en === 1'b1 && (res.y_addr <= X_LAST || res.y_addr > Y_LAST));
    end
  end
endmodule : oag_dspace_model
`default_nettype wire

// ---- sim/oag_core_tb.sv ----
// self-checking bench for the operand address generation core
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module oag_core_tb
  import oag_pkg::*;
;
  logic ref_clk = 1'b0; // 40 MHz
  logic nrst = 1'b0; // held low at start
  oag_instr_s instr = '0; // decoder side, driven on rising edges
  logic wr_en = 1'b0; // datapath write port
  logic [SEL_W-1:0] wr_sel = '0;
  logic [W_WIDTH-1:0] wr_data = '0;
  oag_res_s res; // result of the core
  int x_rd_cnt;
  int y_rd_cnt;
  int bad_cnt;
  int n_fail = 0;
  int comparisons = 0;
  oag_res_s exp_q[$]; // expected notes
  oag_res_s msk_q[$]; // which fields each note fixes
  oag_res_s e; // note being built
  oag_res_s m;
  oag_ea_req_s nd; // harmless filler slot
  logic [W_WIDTH-1:0] rnd; // random literal of the moment
  logic [W_WIDTH-1:0] w5;
  logic [W_WIDTH-1:0] w9;
  logic [W_WIDTH-1:0] w11;
  logic [W_WIDTH-1:0] st;

  // clock: 25 ns period
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  oag_core u_oag_core (.ref_clk(ref_clk), .nrst(nrst), .instr_i(instr), .wr_en_i(wr_en),
    .wr_sel_i(wr_sel), .wr_data_i(wr_data), .res_o(res));
  oag_dspace_model u_oag_dspace_model (.ref_clk(ref_clk), .nrst(nrst), .res(res),
    .x_rd_cnt(x_rd_cnt), .y_rd_cnt(y_rd_cnt), .bad_cnt(bad_cnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic oag_ea_req_s rq(oag_mode_e md, logic [SEL_W-1:0] s, logic [W_WIDTH-1:0] l);
    rq = '{mode: md, base_sel: s, lit: l, file_addr: l};
  endfunction : rq

  // compare the result with a note, masked fields only
  task automatic cmp(oag_res_s ex, oag_res_s mk);
    comparisons++;
    if ((res & mk) !== (ex & mk)) begin
      n_fail++;
      $display("CHECK FAILED res_o expected %h seen %h", ex & mk, res & mk);
    end
  endtask : cmp

  task automatic cmp_cnt(string nm, int ex, int got);
    comparisons++;
    if (ex != got) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : cmp_cnt

  // start a note: valid high, illegal low
  task automatic clr();
    e = '0;
    m = '0;
    e.valid = 1'b1;
    m.valid = 1'b1;
    m.illegal = 1'b1;
  endtask : clr

  task automatic t_src(logic mem, logic [W_WIDTH-1:0] ea);
    {e.src_is_mem, e.src_ea} = {mem, ea};
    {m.src_is_mem, m.src_ea} = '1;
  endtask : t_src

  task automatic t_xy(logic [W_WIDTH-1:0] xa, logic [W_WIDTH-1:0] ya);
    {e.x_en, e.x_addr, e.y_en, e.y_addr} = {1'b1, xa, 1'b1, ya};
    {m.x_en, m.x_addr, m.y_en, m.y_addr} = '1;
  endtask : t_xy

  // refusal: flag up, every address and enable low
  task automatic t_bad();
    e.illegal = 1'b1;
    {m.x_en, m.x_addr, m.y_en, m.y_addr, m.src_ea, m.dst_ea} = '1;
  endtask : t_bad

  // one instruction on the next edge; the note goes in the queue at once
  task automatic go(oag_class_e c, oag_ea_req_s s, oag_ea_req_s d, oag_ea_req_s x,
    oag_ea_req_s y);
    @(posedge ref_clk);
    instr <= '{valid: 1'b1, iclass: c, src: s, dst: d, xreq: x, yreq: y, ofs_sel: 4'h4,
      branch_lit: rnd, intdis_lit: rnd[13:0]};
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask : go

  task automatic idle();
    @(posedge ref_clk);
    instr.valid <= 1'b0;
  endtask : idle

  // write strobe stands for exactly one sampling edge
  task automatic wr(logic [SEL_W-1:0] s, logic [W_WIDTH-1:0] d);
    @(posedge ref_clk);
    {wr_en, wr_sel, wr_data} <= {1'b1, s, d};
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic wrap_up();
    // a note never matched by a result is a missing answer
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("CHECK FAILED note queue expected 0 seen %0d", exp_q.size());
    end
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // result watcher: results are settled by the falling edge
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (nrst === 1'b1 && res.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("CHECK FAILED res_o expected none seen %h", res);
      end else begin
        cmp(exp_q.pop_front(), msk_q.pop_front());
      end
    end
  end

  // hang guard, far above the run length
  initial begin
    #500us;
    n_fail++;
    $display("CHECK FAILED watchdog expected end seen hang");
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2850));
    nd = rq(OAG_M_IND, 4'h0, 16'h0000);
    w5 = 16'($urandom);
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    cmp('0, '1);
    wr(4'h3, 16'h0100);
    wr(4'h4, 16'h0020);
    wr(4'h5, w5);
    wr(4'h8, 16'h0800);
    wr(4'h9, 16'h0900);
    wr(4'hA, 16'h1A00);
    wr(4'hB, 16'h1B00);
    // single-operand modes, back to back
    rnd = 16'($urandom);
    clr(); t_src(1'b1, rnd); go(OAG_C_ORD, rq(OAG_M_FILE, 4'h0, rnd), nd, nd, nd);
    clr(); t_src(1'b0, w5); e.src_opnd = w5; m.src_opnd = '1;
    go(OAG_C_ORD, rq(OAG_M_REG, 4'h5, 16'h0000), nd, nd, nd);
    clr(); t_src(1'b1, 16'h0100); go(OAG_C_ORD, rq(OAG_M_IND, 4'h3, 16'h0000), nd, nd, nd);
    clr(); t_src(1'b1, 16'h0100); go(OAG_C_ORD, rq(OAG_M_POST, 4'h3, 16'h0002), nd, nd, nd);
    clr(); t_src(1'b1, 16'h00FE); go(OAG_C_ORD, rq(OAG_M_PRE, 4'h3, 16'hFFFC), nd, nd, nd);
    clr(); t_src(1'b1, 16'h011E); e.dst_ea = 16'h0820; m.dst_ea = '1;
    e.dst_is_mem = 1'b1; m.dst_is_mem = 1'b1;
    go(OAG_C_MOVE, rq(OAG_M_REGOFS, 4'h3, 16'h0), rq(OAG_M_REGOFS, 4'h8, 16'h0), nd, nd);
    clr(); t_src(1'b1, 16'h010E); go(OAG_C_MOVE, rq(OAG_M_LITOFS, 4'h3, 16'h0010), nd, nd, nd);
    clr(); t_src(1'b1, 16'h00FE); go(OAG_C_ORD, rq(OAG_M_IND, 4'h3, 16'h0000), nd, nd, nd);
    clr(); t_bad(); go(OAG_C_ORD, rq(OAG_M_REGOFS, 4'h3, 16'h0000), nd, nd, nd);
    idle();
    @(negedge ref_clk);
    @(negedge ref_clk);
    cmp('0, '1);
    $display("test single operand modes done");
    // dual-source prefetch; pointers named from 8..11 only except the pointer 3 refusal case
    w9 = 16'h0900;
    w11 = 16'h1B00;
    clr(); t_xy(16'h0800, 16'h1A00);
    go(OAG_C_DUAL, nd, nd, rq(OAG_M_IND, 4'h8, 16'h0), rq(OAG_M_IND, 4'hA, 16'h0));
    for (int k = 1; k <= 3; k++) begin
      st = 16'(2 * k);
      clr(); t_xy(w9, w11);
      go(OAG_C_DUAL, nd, nd, rq(OAG_M_POST, 4'h9, st), rq(OAG_M_POST, 4'hB, -st));
      w9 = w9 + st;
      w11 = w11 - st;
    end
    clr(); t_bad();
    go(OAG_C_DUAL, nd, nd, rq(OAG_M_POST, 4'h9, 16'h8), rq(OAG_M_POST, 4'hB, 16'h8));
    clr(); t_xy(w9 + 16'h0020, w11 + 16'h0020);
    go(OAG_C_DUAL, nd, nd, rq(OAG_M_REGOFS, 4'h9, 16'h0), rq(OAG_M_REGOFS, 4'hB, 16'h0));
    clr(); t_bad();
    go(OAG_C_DUAL, nd, nd, rq(OAG_M_REGOFS, 4'h8, 16'h0), rq(OAG_M_REGOFS, 4'hB, 16'h0));
    clr(); t_bad();
    go(OAG_C_DUAL, nd, nd, rq(OAG_M_IND, 4'h3, 16'h0), rq(OAG_M_IND, 4'hA, 16'h0));
    clr(); t_bad();
    go(OAG_C_DUAL, nd, nd, rq(OAG_M_PRE, 4'h8, 16'h2), rq(OAG_M_IND, 4'hA, 16'h0));
    idle();
    $display("test dual source prefetch done");
    // literal and implied classes
    rnd = 16'($urandom) | 16'hC000;
    clr(); e.target = rnd; m.target = '1; go(OAG_C_BRANCH, nd, nd, nd, nd);
    clr(); e.intdis_cnt = rnd[13:0]; m.intdis_cnt = '1; go(OAG_C_INTDIS, nd, nd, nd, nd);
    clr(); e.implied = 1'b1; m.implied = '1; go(OAG_C_IMPL, nd, nd, nd, nd);
    idle();
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge ref_clk);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("CHECK FAILED result wait expected empty queue seen %0d", exp_q.size());
    end
    cmp_cnt("x reads", 5, x_rd_cnt);
    cmp_cnt("y reads", 5, y_rd_cnt);
    cmp_cnt("out of space reads", 0, bad_cnt);
    $display("test literal classes done");
    // second reset in mid-run clears the working registers
    @(posedge ref_clk);
    nrst <= 1'b0;
    // outputs must be cleared while reset is held
    @(negedge ref_clk);
    cmp('0, '1);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    clr(); t_src(1'b1, 16'h0000); go(OAG_C_ORD, rq(OAG_M_IND, 4'h3, 16'h0000), nd, nd, nd);
    idle();
    repeat (3) @(negedge ref_clk);
    $display("test second reset done");
    wrap_up();
  end
endmodule : oag_core_tb
`default_nettype wire
